// ==== include/mdcc_pkg.sv ====
// Constants, types and helpers of the two-channel memory-to-memory DMA block.
// Assumes one 200 MHz clock and a simplified single-master AHB port.
package mdcc_pkg;
   // =========================================================
   // Map
   localparam int         NCH       = 2;
   localparam logic [5:0] OFS_CTRL  = 6'h00;
   localparam logic [5:0] OFS_IRQ   = 6'h04;
   localparam logic [5:0] OFS_STAT  = 6'h0C;
   localparam logic [5:0] OFS_BC0   = 6'h10;
   localparam logic [5:0] OFS_BC1   = 6'h14;
   localparam logic [5:0] OFS_SS0   = 6'h18;
   localparam logic [5:0] OFS_SS1   = 6'h1C;
   localparam logic [5:0] OFS_SN0   = 6'h24;
   localparam logic [5:0] OFS_SN1   = 6'h28;
   localparam logic [5:0] OFS_DS0   = 6'h2C;
   localparam logic [5:0] OFS_DS1   = 6'h30;
   localparam logic [5:0] OFS_DN0   = 6'h34;
   localparam logic [5:0] OFS_DN1   = 6'h3C;
   localparam logic [31:0] REG_RST  = 32'h0000_0000;
   localparam logic [31:0] CTRL_WMASK = 32'hFFFB_FFEF;
   // =========================================================
   // Fields
   localparam int CB_STALL_IE = 0;
   localparam int CB_FILL     = 1;
   localparam int CB_DONE_IE  = 2;
   localparam int CB_EN       = 3;
   localparam int CB_START    = 4;
   localparam int CB_BWC_LO   = 5;
   localparam int CB_PW_LO    = 9;
   localparam int CB_DAH      = 11;
   localparam int CB_SAH      = 12;
   localparam int CB_TM_LO    = 13;
   localparam int CB_NFB_IE   = 21;
   localparam int IB_STALL    = 0;
   localparam int IB_DONE     = 1;
   localparam int IB_NFB      = 2;
   localparam int SB_STALL    = 0;
   localparam int SB_STATE_LO = 1;
   localparam int SB_DONE     = 6;
   localparam int SB_NFB      = 11;
   localparam int SB_NB       = 12;
   localparam logic [15:0] REL_WIN = 16'h000F;
   localparam logic [1:0]  HT_IDLE = 2'b00;
   localparam logic [1:0]  HT_NSEQ = 2'b10;
   localparam logic [2:0]  HS_WORD = 3'b010;
   // =========================================================
   // Types
   typedef enum logic [1:0] {TM_SW = 2'b00, TM_TO_DEV = 2'b01,
      TM_FROM_DEV = 2'b10, TM_NONE = 2'b11} mdcc_tm_t;
   typedef enum logic [1:0] {CS_IDLE = 2'b00, CS_STALL = 2'b01,
      CS_ON = 2'b10, CS_DONE = 2'b11} mdcc_cs_t;
   typedef enum logic [2:0] {BS_IDLE = 3'b000, BS_RA = 3'b001,
      BS_RD = 3'b010, BS_WA = 3'b011, BS_WD = 3'b100} mdcc_bs_t;
   typedef struct packed {
      logic        busreq;
      logic [1:0]  trans;
      logic        write;
      logic [2:0]  size;
      logic [31:0] addr;
      logic [31:0] wdata;
   } mdcc_ahb_t;
   typedef struct packed {
      logic [31:0]       ctrl;
      logic [2:0]        irq;
      logic              done_seen;
      mdcc_cs_t          cs;
      logic              cur;
      logic              nb;
      logic [1:0]        dv;
      logic [1:0][15:0]  bc;
      logic [1:0][31:0]  ss;
      logic [1:0][31:0]  sn;
      logic [1:0][31:0]  ds;
      logic [1:0][31:0]  dn;
      logic [15:0]       rem;
      logic [31:0]       data;
      logic              have_word;
      logic              rel_done;
   } mdcc_ch_t;
   // =========================================================
   // Helpers
   function automatic mdcc_tm_t mdcc_tm(input logic [31:0] c);
      return mdcc_tm_t'(c[CB_TM_LO+:2]);
   endfunction
   function automatic logic mdcc_fill(input logic [31:0] c);
      return c[CB_FILL] && (mdcc_tm(c) == TM_SW);
   endfunction
   function automatic logic [15:0] mdcc_blk(input logic [3:0] b);
      if (b == 4'h0) return 16'h0000;
      if (b <= 4'h4) return 16'h0010;
      return 16'h0001 << b;
   endfunction
endpackage

// ==== src/mdcc_bw_gate.sv ====
// Bus release window check for one channel.
// Assumes the remaining byte count of the active buffer.
`timescale 1ns/1ps
module mdcc_bw_gate
   import mdcc_pkg::*;
(
   input  wire logic [3:0]  i_bwc,
   input  wire mdcc_tm_t    i_tm,
   input  wire logic [15:0] i_rem,
   output logic             o_release
);
   logic [15:0] blk;
   // =========================================================
   // Window decode
   always_comb begin
      blk = mdcc_blk(i_bwc); // RL18
      o_release = (i_tm == TM_SW) && (blk != 16'h0000) // RL19
         && (i_rem != 16'h0000)
         && ((i_rem & (blk - 16'h0001)) <= REL_WIN); // RL17
   end
endmodule // mdcc_bw_gate

// ==== src/mdcc_top.sv ====
// Two memory-to-memory DMA channels with register port and AHB master.
// Assumes a single synchronous clock and one AHB arbiter grant line.
//
// Summary of operation
// RL1 - Two channels, identical register layout
// RL2 - Write to flag register clears flags
// RL3 - Software programs control before enabling
// RL4 - Stall flag raised in stall if enabled
// RL5 - Fill mode reads once, writes many
// RL6 - Source advances by transfer size otherwise
// RL7 - Fill mode ignores two address LSBs
// RL8 - Fill honoured only in software mode
// RL9 - Done flag on completion if enabled
// RL10 - Enable bit enables, clear disables
// RL11 - Addresses and counts written before enable
// RL12 - Disabled channel keeps handshake inactive
// RL13 - Start launches transfer, reads zero
// RL14 - Start only after configure and enable
// RL15 - Start ignored in external modes
// RL16 - Roll over to programmed second buffer
// RL17 - Drop bus request near block multiple
// RL18 - Block size decode table
// RL19 - Block size ignored in external mode
// RL20 - External drops request per transfer
// RL21 - Transfer mode field decode
// RL22 - Done flag blocks requests until cleared
// RL23 - Reserved locations read zero
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module mdcc_top
   import mdcc_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_sys_rst,
   input  wire logic [6:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic [31:0]      o_rdata,
   input  wire logic        i_hgrant,
   input  wire logic        i_hready,
   input  wire logic [31:0] i_hrdata,
   output mdcc_ahb_t        o_ahb,
   input  wire logic [1:0]  i_dreq,
   output logic [1:0]       o_dack
);
   typedef struct packed {
      mdcc_ch_t [1:0] ch;
      mdcc_bs_t       bs;
      logic           sel;
      mdcc_ahb_t      ahb;
      logic [31:0]    rdata;
      logic [1:0]     dack;
   } mdcc_st_t;

   mdcc_st_t   q;
   mdcc_st_t   d;
   logic [1:0] rel;
   logic [1:0] want;
   mdcc_ch_t   sc;

   // =========================================================
   // Bandwidth gates
   for (genvar g = 0; g < NCH; g++) begin : g_bw
      mdcc_bw_gate u_bw (
         .i_bwc     (q.ch[g].ctrl[CB_BWC_LO+:4]),
         .i_tm      (mdcc_tm(q.ch[g].ctrl)),
         .i_rem     (q.ch[g].rem),
         .o_release (rel[g])
      );
   end

   // =========================================================
   // Buffer load
   function automatic mdcc_ch_t load_buf(input mdcc_ch_t c, input logic b);
      mdcc_ch_t r;
      r = c;
      r.cur = b;
      r.rem = c.bc[b];
      r.sn[b] = mdcc_fill(c.ctrl) ? {c.ss[b][31:2], 2'b00} : c.ss[b]; // RL7
      r.dn[b] = mdcc_fill(c.ctrl) ? {c.ds[b][31:2], 2'b00} : c.ds[b]; // RL7
      r.have_word = 1'b0;
      r.rel_done = 1'b0;
      r.cs = CS_ON;
      return r;
   endfunction

   function automatic logic [31:0] step_of(input logic [31:0] c);
      if (mdcc_tm(c) == TM_SW) return 32'h0000_0004;
      return 32'h0000_0001 << c[CB_PW_LO+:2];
   endfunction

   // =========================================================
   // Next state
   always_comb begin
      logic start;
      logic k;
      logic wr_c;
      mdcc_tm_t tm;
      logic [31:0] stp;
      d = q;
      stp = 32'h0000_0000;
      start = 1'b0;
      wr_c = 1'b0;
      tm = TM_SW;
      k = i_addr[6];
      sc = q.ch[q.sel];
      d.dack = 2'b00;
      d.rdata = REG_RST;
      for (int c = 0; c < NCH; c++) begin // RL1
         tm = mdcc_tm(q.ch[c].ctrl); // RL21
         want[c] = (q.ch[c].cs == CS_ON) && (q.ch[c].rem != 16'h0000)
            && ((tm == TM_SW) ? !(rel[c] && !q.ch[c].rel_done) // RL17
            : (i_dreq[c] && (tm != TM_NONE)));
         if ((q.ch[c].cs == CS_ON) && (q.ch[c].rem != 16'h0000)
            && (tm == TM_SW) && rel[c] && !q.ch[c].rel_done) begin
            d.ch[c].rel_done = 1'b1; // RL17
         end
      end
      // =========================================================
      // Bus sequencer
      case (q.bs)
         BS_IDLE: begin
            d.ahb.trans = HT_IDLE;
            d.ahb.write = 1'b0;
            d.ahb.busreq = |want;
            if (q.ahb.busreq && (|want) && i_hgrant && i_hready) begin
               d.sel = !want[0];
               sc = q.ch[!want[0]];
               d.ahb.trans = HT_NSEQ;
               d.ahb.size = mdcc_tm(sc.ctrl) == TM_SW ? HS_WORD
                  : {1'b0, sc.ctrl[CB_PW_LO+:2]};
               if (mdcc_fill(sc.ctrl) && sc.have_word) begin // RL5 RL8
                  d.ahb.write = 1'b1;
                  d.ahb.addr = sc.dn[sc.cur];
                  d.bs = BS_WA;
               end else begin
                  d.ahb.addr = sc.sn[sc.cur];
                  d.bs = BS_RA;
               end
            end
         end
         BS_RA: begin
            if (i_hready) begin
               d.ahb.trans = HT_IDLE;
               d.bs = BS_RD;
            end
         end
         BS_RD: begin
            if (i_hready) begin
               d.ch[q.sel].data = i_hrdata;
               d.ch[q.sel].have_word = 1'b1;
               d.ahb.addr = sc.dn[sc.cur];
               d.ahb.write = 1'b1;
               d.ahb.trans = HT_NSEQ;
               d.bs = BS_WA;
            end
         end
         BS_WA: begin
            if (i_hready) begin
               d.ahb.trans = HT_IDLE;
               d.ahb.wdata = sc.data;
               d.bs = BS_WD;
            end
         end
         BS_WD: begin
            if (i_hready) begin
               d.ahb.write = 1'b0;
               d.ahb.busreq = mdcc_tm(sc.ctrl) == TM_SW; // RL20
               d.dack[q.sel] = (mdcc_tm(sc.ctrl) != TM_SW)
                  && sc.ctrl[CB_EN];
               stp = step_of(sc.ctrl);
               d.ch[q.sel].rem = sc.rem - stp[15:0];
               d.ch[q.sel].rel_done = 1'b0;
               if (!mdcc_fill(sc.ctrl) && !sc.ctrl[CB_SAH]) begin // RL6
                  d.ch[q.sel].sn[sc.cur] = sc.sn[sc.cur] + step_of(sc.ctrl);
               end
               if (!sc.ctrl[CB_DAH]) begin
                  d.ch[q.sel].dn[sc.cur] = sc.dn[sc.cur] + step_of(sc.ctrl);
               end
               d.bs = BS_IDLE;
            end
         end
         default: begin
            d.bs = BS_IDLE;
         end
      endcase
      // =========================================================
      // Register writes and channel sequencers
      for (int c = 0; c < NCH; c++) begin
         wr_c = i_wr && (k == c[0]);
         start = 1'b0;
         if (wr_c) begin
            case (i_addr[5:0])
               OFS_CTRL: begin
                  d.ch[c].ctrl = i_wdata & CTRL_WMASK; // RL10 RL23
                  start = i_wdata[CB_START] && i_wdata[CB_EN] // RL13
                     && (mdcc_tm(i_wdata) == TM_SW); // RL15
               end
               OFS_IRQ: begin
                  d.ch[c].irq = 3'b000; // RL2
                  d.ch[c].done_seen = 1'b0; // RL22
               end
               OFS_BC0, OFS_BC1: begin
                  d.ch[c].bc[i_addr[2]] = i_wdata[15:0];
                  d.ch[c].dv[i_addr[2]] = 1'b1; // RL16
                  d.ch[c].nb = !i_addr[2];
                  d.ch[c].irq[IB_NFB] = 1'b0;
               end
               OFS_SS0: d.ch[c].ss[0] = i_wdata;
               OFS_SS1: d.ch[c].ss[1] = i_wdata;
               OFS_DS0: d.ch[c].ds[0] = i_wdata;
               OFS_DS1: d.ch[c].ds[1] = i_wdata;
               default: d.ch[c].cs = d.ch[c].cs; // RL23
            endcase
         end
         tm = mdcc_tm(q.ch[c].ctrl);
         if (!d.ch[c].ctrl[CB_EN]) begin // RL10
            d.ch[c].cs = CS_IDLE;
            d.ch[c].irq[IB_STALL] = 1'b0;
            d.ch[c].irq[IB_NFB] = 1'b0;
            d.dack[c] = 1'b0; // RL12
         end else begin
            case (q.ch[c].cs)
               CS_IDLE: begin
                  if (!q.ch[c].done_seen && (start // RL22
                     || ((tm != TM_SW) && (tm != TM_NONE)))) begin // RL15
                     if (d.ch[c].dv[q.ch[c].cur]) begin
                        d.ch[c] = load_buf(d.ch[c], q.ch[c].cur);
                     end else begin
                        d.ch[c].cs = CS_STALL;
                     end
                  end
               end
               CS_STALL: begin
                  if (q.ch[c].ctrl[CB_STALL_IE]) begin
                     d.ch[c].irq[IB_STALL] = 1'b1; // RL4
                  end
                  if (d.ch[c].dv[q.ch[c].cur]) begin
                     d.ch[c] = load_buf(d.ch[c], q.ch[c].cur);
                  end
               end
               CS_ON: begin
                  if ((q.ch[c].rem == 16'h0000)
                     && !((q.bs != BS_IDLE) && (q.sel == c[0]))) begin
                     d.ch[c].dv[q.ch[c].cur] = 1'b0;
                     if (d.ch[c].dv[!q.ch[c].cur]) begin // RL16
                        d.ch[c] = load_buf(d.ch[c], !q.ch[c].cur);
                        if (q.ch[c].ctrl[CB_NFB_IE]) begin
                           d.ch[c].irq[IB_NFB] = 1'b1;
                        end
                     end else begin
                        d.ch[c].cs = CS_DONE;
                        d.ch[c].done_seen = 1'b1; // RL22
                        if (q.ch[c].ctrl[CB_DONE_IE]) begin
                           d.ch[c].irq[IB_DONE] = 1'b1; // RL9
                        end
                     end
                  end
               end
               CS_DONE: begin
                  if (!d.ch[c].done_seen) begin
                     d.ch[c].cs = CS_IDLE;
                  end
               end
               default: d.ch[c].cs = CS_IDLE;
            endcase
         end
      end
      // =========================================================
      // Read port
      if (i_rd) begin
         case (i_addr[5:0])
            OFS_CTRL: d.rdata = q.ch[k].ctrl; // RL13
            OFS_IRQ:  d.rdata = {29'h0000_0000, q.ch[k].irq};
            OFS_STAT: begin
               d.rdata[SB_STALL] = q.ch[k].cs == CS_STALL;
               d.rdata[SB_STATE_LO+:2] = q.ch[k].cs;
               d.rdata[SB_DONE] = q.ch[k].done_seen;
               d.rdata[SB_NFB] = q.ch[k].irq[IB_NFB];
               d.rdata[SB_NB] = q.ch[k].nb;
            end
            OFS_BC0:  d.rdata = {16'h0000, q.ch[k].bc[0]};
            OFS_BC1:  d.rdata = {16'h0000, q.ch[k].bc[1]};
            OFS_SS0:  d.rdata = q.ch[k].ss[0];
            OFS_SS1:  d.rdata = q.ch[k].ss[1];
            OFS_SN0:  d.rdata = q.ch[k].sn[0];
            OFS_SN1:  d.rdata = q.ch[k].sn[1];
            OFS_DS0:  d.rdata = q.ch[k].ds[0];
            OFS_DS1:  d.rdata = q.ch[k].ds[1];
            OFS_DN0:  d.rdata = q.ch[k].dn[0];
            OFS_DN1:  d.rdata = q.ch[k].dn[1];
            default:  d.rdata = REG_RST; // RL23
         endcase
      end
   end

   // =========================================================
   // State register
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_rdata = q.rdata;
   assign o_ahb   = q.ahb;
   assign o_dack  = q.dack;

   // =========================================================
   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   logic fill_sel;
   logic ext_sel;
   assign fill_sel = mdcc_fill(q.ch[q.sel].ctrl);
   assign ext_sel = mdcc_tm(q.ch[q.sel].ctrl) != TM_SW;

   dack_off_a: assert property ( // RL12
      !q.ch[0].ctrl[CB_EN] |=> !o_dack[0])
      else $error("handshake active on disabled channel");
   start_zero_a: assert property ( // RL13
      i_rd && (i_addr == {1'b0, OFS_CTRL}) |=> !o_rdata[CB_START])
      else $error("start bit read back as one");
   stall_flag_a: assert property ( // RL4
      (q.ch[0].cs == CS_STALL) && q.ch[0].ctrl[CB_STALL_IE]
      && q.ch[0].ctrl[CB_EN] && !i_wr |=> q.ch[0].irq[IB_STALL])
      else $error("stall flag missing");
   stall_quiet_a: assert property ( // RL4
      !q.ch[0].ctrl[CB_STALL_IE] && !q.ch[0].irq[IB_STALL]
      |=> !q.ch[0].irq[IB_STALL])
      else $error("stall flag without enable");
   done_flag_a: assert property ( // RL9
      (q.ch[0].cs == CS_DONE) && ($past(q.ch[0].cs) == CS_ON)
      && $past(q.ch[0].ctrl[CB_DONE_IE]) |-> q.ch[0].irq[IB_DONE])
      else $error("done flag missing");
   flag_clear_a: assert property ( // RL2
      i_wr && (i_addr == {1'b0, OFS_IRQ}) && (q.ch[0].cs == CS_IDLE)
      |=> (q.ch[0].irq == 3'b000) && !q.ch[0].done_seen)
      else $error("flag write did not clear");
   fill_align_a: assert property ( // RL7
      (q.bs == BS_WA) && fill_sel |-> (o_ahb.addr[1:0] == 2'b00))
      else $error("fill address not word aligned");
   ext_drop_a: assert property ( // RL20
      (q.bs == BS_WD) && i_hready && ext_sel |=> !o_ahb.busreq)
      else $error("request held after external transfer");
   sw_hold_a: assert property ( // RL20
      (q.bs == BS_WD) && i_hready && !ext_sel |=> o_ahb.busreq)
      else $error("request dropped in software mode");
   done_block_a: assert property ( // RL22
      (q.ch[0].cs == CS_DONE) && q.ch[0].ctrl[CB_EN] && !i_wr
      |=> (q.ch[0].cs == CS_DONE) && q.ch[0].done_seen)
      else $error("left done state without clearing flag");

   done_cv: cover property (q.ch[0].cs == CS_ON ##[1:200] q.ch[0].cs == CS_DONE);
   roll_cv: cover property (q.ch[0].irq[IB_NFB]);
   stall_cv: cover property (q.ch[1].cs == CS_STALL);
endmodule // mdcc_top

// ==== verif/mdcc_mem_model.sv ====
// AHB memory partner of the DMA block: grant, wait states, word store.
// Assumes one requesting master and addresses below 1 KB.
`timescale 1ns/1ps
module mdcc_mem_model
   import mdcc_pkg::*;
(
   input  wire logic      i_clk,
   input  wire logic      i_rst,
   input  wire logic      i_slow,
   input  wire mdcc_ahb_t i_ahb,
   output logic           o_hgrant,
   output logic           o_hready,
   output logic [31:0]    o_hrdata
);
   // ==========================================
   // Data phase state
   logic [31:0] mem_q [0:255];
   logic        vld_q;
   logic        wr_q;
   logic [7:0]  adr_q;
   logic [15:0] rnd_q;
   logic [31:0] last_q;
   int          rd_cnt;
   int          bad_cnt;
   // Released bus shows inverse of last word
   assign o_hrdata = (vld_q && !wr_q) ? mem_q[adr_q] : ~last_q;
   always @(posedge i_clk) begin
      if (i_rst) begin
         vld_q    <= 1'b0;
         o_hready <= 1'b1;
         o_hgrant <= 1'b0;
         rnd_q    <= 16'h1d5b;
         last_q   <= 32'h0000_0000;
      end else begin
         rnd_q    <= {rnd_q[14:0], rnd_q[15] ^ rnd_q[13] ^ rnd_q[12] ^ rnd_q[10]};
         o_hgrant <= i_ahb.busreq;
         o_hready <= !i_slow || rnd_q[0];
         if (o_hready) begin
            if (vld_q && wr_q)
               mem_q[adr_q] <= i_ahb.wdata;
            if (vld_q && !wr_q)
               last_q <= mem_q[adr_q];
            vld_q <= (i_ahb.trans == HT_NSEQ);
            adr_q <= i_ahb.addr[9:2];
            wr_q  <= i_ahb.write;
            if (i_ahb.trans == HT_NSEQ && !i_ahb.write)
               rd_cnt++;
            if (i_ahb.trans == HT_NSEQ && i_ahb.size == HS_WORD && i_ahb.addr[1:0] != 2'b00)
               bad_cnt++;
         end
      end
   end
endmodule // mdcc_mem_model

// ==== verif/testbench.sv ====
// Self-checking bench of the two-channel DMA block.
// Assumes the memory partner model and a 200 MHz clock.
`timescale 1ns/1ps
module testbench
   import mdcc_pkg::*;
;
   // ==========================================
   // Signals
   localparam logic [31:0] zero32 = 32'h0000_0000;
   localparam logic [3:0]  bwc_set [4] = '{4'h0, 4'h4, 4'h5, 4'hf};
   logic        clk;
   logic        rst;
   logic [6:0]  addr;
   logic [31:0] wdata;
   logic        wr;
   logic        rd;
   logic [31:0] rdata;
   logic        hgrant;
   logic        hready;
   logic [31:0] hrdata;
   mdcc_ahb_t   ahb;
   logic [1:0]  dreq;
   logic [1:0]  dack;
   logic        slow;
   logic        bq;
   logic [31:0] seed;
   logic [31:0] rv;
   logic [31:0] exp_mem [0:255];
   int          num_errors;
   int          checked;
   int          cyc;
   int          rises;
   int          nd0;
   int          nd1;
   int          i;
   int          r0;
   mdcc_top dut (.i_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_hgrant(hgrant), .i_hready(hready),
      .i_hrdata(hrdata), .o_ahb(ahb), .i_dreq(dreq), .o_dack(dack));
   mdcc_mem_model u_mem (.i_clk(clk), .i_rst(rst), .i_slow(slow), .i_ahb(ahb),
      .o_hgrant(hgrant), .o_hready(hready), .o_hrdata(hrdata));
   // ==========================================
   // Clock, monitor, timeout
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      bq <= ahb.busreq;
      if (ahb.busreq && !bq)
         rises++;
      nd0 = nd0 + int'(dack[0]);
      nd1 = nd1 + int'(dack[1]);
      if (cyc == 20000) begin
         num_errors++;
         report_and_stop();
      end
   end
   // ==========================================
   // Helpers
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c1_1db7 : zero32);
   endfunction
   function automatic int drops(input logic [3:0] c, input int n);
      int blk;
      int dr;
      blk = (c == 4'h0) ? 0 : (c <= 4'h4) ? 16 : (1 << c);
      dr = 0;
      for (int r = n - 4; r > 0; r -= 4)
         if (blk != 0 && r % blk <= 15)
            dr++;
      return dr;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [6:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [6:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic rchk(input logic [6:0] a, input logic [31:0] e);
      logic [31:0] d;
      rd_reg(a, d);
      chk(d, e);
   endtask
   task automatic do_reset();
      @(posedge clk);
      rst <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
   endtask
   task automatic wait_done(input logic ch);
      logic [31:0] s;
      s = zero32;
      for (int k = 0; k < 300 && s[2:1] != 2'b11; k++)
         rd_reg({ch, OFS_STAT}, s);
      chk({30'h0000_0000, s[2:1]}, 32'h0000_0003);
   endtask
   task automatic sw_copy(input logic ch, input logic [31:0] s, d, s1, d1,
                          input logic [15:0] n, n1, input logic [31:0] c);
      wr_reg({ch, OFS_IRQ}, zero32);
      wr_reg({ch, OFS_CTRL}, zero32);
      wr_reg({ch, OFS_SS0}, s);
      wr_reg({ch, OFS_DS0}, d);
      wr_reg({ch, OFS_BC0}, {16'h0000, n});
      if (n1 != 16'h0000) begin
         wr_reg({ch, OFS_SS1}, s1);
         wr_reg({ch, OFS_DS1}, d1);
         wr_reg({ch, OFS_BC1}, {16'h0000, n1});
      end
      @(negedge clk);
      rises = 0;
      wr_reg({ch, OFS_CTRL}, c);
      wait_done(ch);
      for (int k = 0; k < n / 4; k++)
         exp_mem[d[9:2] + k] = c[CB_FILL] ? exp_mem[s[9:2]] : exp_mem[s[9:2] + k];
      for (int k = 0; k < n1 / 4; k++)
         exp_mem[d1[9:2] + k] = exp_mem[s1[9:2] + k];
      for (int k = 0; k < 256; k++)
         chk(u_mem.mem_q[k], exp_mem[k]);
   endtask
   task automatic report_and_stop();
      $display("errors %0d, comparisons %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // ==========================================
   // Sequence
   initial begin
      {rst, wr, rd, slow, bq} = 5'b10000;
      {addr, wdata, dreq} = '0;
      {num_errors, checked, cyc, rises, nd0, nd1} = '0;
      seed = 32'h43d0_1d5b;
      for (i = 0; i < 256; i++) begin
         seed = lfsr(seed);
         exp_mem[i] = seed;
         u_mem.mem_q[i] = seed;
      end
      do_reset();
      for (i = 0; i < 32; i++)
         rchk(7'(i * 4), zero32);
      seed = lfsr(seed);
      rv = seed & 32'hffff_fff7;
      wr_reg({1'b1, OFS_CTRL}, rv);
      rchk({1'b1, OFS_CTRL}, rv & CTRL_WMASK);
      wr_reg({1'b1, OFS_BC1}, seed);
      rchk({1'b1, OFS_BC1}, {16'h0000, seed[15:0]});
      wr_reg({1'b1, OFS_DS1}, ~seed);
      rchk({1'b1, OFS_DS1}, ~seed);
      wr_reg({1'b1, OFS_SN0}, seed);
      rchk({1'b1, OFS_SN0}, zero32);
      wr_reg({1'b1, 6'h08}, seed);
      rchk({1'b1, 6'h08}, zero32);
      do_reset();
      rchk({1'b1, OFS_CTRL}, zero32);
      for (i = 0; i < 2; i++) begin
         wr_reg({1'b0, OFS_CTRL}, 32'h0000_0018 | 32'(i));
         rchk({1'b0, OFS_STAT}, 32'h0000_0003);
         rchk({1'b0, OFS_IRQ}, 32'(i));
         wr_reg({1'b0, OFS_CTRL}, zero32);
         rchk({1'b0, OFS_STAT}, zero32);
      end
      for (i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         slow <= seed[0];
         sw_copy(1'b0, zero32, 32'h0000_0100, zero32, zero32, 16'h0080, 16'h0000,
                 32'h0000_001c | (32'(bwc_set[i]) << CB_BWC_LO));
         chk(32'(rises), 32'(1 + drops(bwc_set[i], 128)));
         rchk({1'b0, OFS_IRQ}, 32'h0000_0002);
         rchk({1'b0, OFS_SN0}, 32'h0000_0080);
      end
      wr_reg({1'b0, OFS_IRQ}, seed);
      rchk({1'b0, OFS_IRQ}, zero32);
      r0 = u_mem.rd_cnt;
      sw_copy(1'b1, 32'h0000_0041, 32'h0000_0302, zero32, zero32, 16'h000c, 16'h0000,
              32'h0000_001a);
      chk(32'(u_mem.rd_cnt - r0), 32'h0000_0001);
      chk(32'(u_mem.bad_cnt), zero32);
      rchk({1'b1, OFS_IRQ}, zero32);
      rd_reg({1'b1, OFS_STAT}, rv);
      chk(rv & 32'h0000_0040, 32'h0000_0040);
      sw_copy(1'b0, 32'h0000_0200, 32'h0000_0240, 32'h0000_0280, 32'h0000_02c0,
              16'h0010, 16'h0010, 32'h0020_0018);
      rchk({1'b0, OFS_IRQ}, 32'h0000_0004);
      wr_reg({1'b1, OFS_CTRL}, 32'h0000_2400);
      dreq <= 2'b11;
      @(negedge clk);
      nd0 = 0;
      nd1 = 0;
      repeat (10) @(negedge clk);
      chk(32'(nd1), zero32);
      sw_copy(1'b1, 32'h0000_0060, 32'h0000_0380, zero32, zero32, 16'h0008, 16'h0000,
              32'h0000_2438);
      chk(32'(nd1), 32'h0000_0002);
      chk(32'(nd0), zero32);
      chk(32'(rises), 32'h0000_0002);
      repeat (30) @(negedge clk);
      chk(32'(nd1), 32'h0000_0002);
      dreq <= 2'b00;
      report_and_stop();
   end
endmodule // testbench
